// ### shared/dual_map_pkg.sv
// Purpose: shared constants and register identities for the dual map decoder
// Assumes: 8-bit host bus, 3-bit register select
// Notes:   page-in command codes sit in the auxiliary command byte
package dual_map_pkg;

  // register select codes
  localparam logic [2:0] SEL_0 = 3'h0;
  localparam logic [2:0] SEL_1 = 3'h1;
  localparam logic [2:0] SEL_2 = 3'h2;
  localparam logic [2:0] SEL_3 = 3'h3;
  localparam logic [2:0] SEL_4 = 3'h4;
  localparam logic [2:0] SEL_5 = 3'h5;
  localparam logic [2:0] SEL_6 = 3'h6;
  localparam logic [2:0] SEL_7 = 3'h7;

  // auxiliary page-in command encodings
  localparam logic [7:0] A_PAGE_CMD  = 8'h50;
  localparam logic [7:0] B_PAGE_MASK = 8'hFC;
  localparam logic [7:0] B_PAGE_CODE = 8'h50;
  localparam int         SWAP_LSB    = 0;
  localparam int         SWAP_W      = 2;

  // swap choices for map B select two
  localparam logic [1:0] SWAP_MASK_TWO = 2'h0;
  localparam logic [1:0] SWAP_TERM     = 2'h1;
  localparam logic [1:0] SWAP_LINE     = 2'h2;
  localparam logic [1:0] SWAP_EXTRA    = 2'h3;

  // reset and idle values
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // every register reachable through either map
  typedef enum logic [5:0] {
    REG_NONE,
    A_RX_BYTE, A_TX_BYTE_OR_CMD,
    A_EVENT_FLAGS_ONE, A_EVENT_ENABLE_ONE,
    A_EVENT_FLAGS_TWO, A_EVENT_ENABLE_TWO,
    A_POLL_RESPONSE_STATE, A_POLL_RESPONSE_SETUP,
    A_CHIP_REVISION, A_CLOCK_DIVIDER_SETTING,
    A_ADDRESSING_STATE, A_ADDRESSING_SETUP,
    A_PASSED_COMMAND, A_AUX_COMMAND_PORT, A_HANDSHAKE_STATE,
    A_PRIMARY_ADDR_READBACK, A_OWN_BUS_ADDRESS,
    A_EVENT_FLAGS_ZERO, A_EVENT_ENABLE_ZERO,
    A_SECONDARY_ADDR_READBACK, A_TERMINATOR_CHAR,
    A_LINE_STATE, A_LINE_CONTROL,
    B_EVENT_FLAGS_ZERO, B_EVENT_ENABLE_ZERO,
    B_EVENT_FLAGS_ONE, B_EVENT_ENABLE_ONE,
    B_ADDRESSING_STATE, B_EVENT_ENABLE_TWO,
    B_TERMINATOR_CHAR, B_LINE_CONTROL, B_EXTRA_SETTINGS,
    B_LINE_STATE, B_AUX_COMMAND_PORT,
    B_EVENT_FLAGS_TWO, B_OWN_BUS_ADDRESS,
    B_POLL_RESPONSE_STATE, B_POLL_RESPONSE_SETUP,
    B_PASSED_COMMAND, B_GROUP_POLL_SETUP,
    B_RX_BYTE, B_TX_BYTE_OR_CMD
  } reg_id_t;

endpackage : dual_map_pkg

// ### core/dual_map_host_register_decoder.sv
// Purpose: host register decoder with primary map A and alternate map B
// Assumes: host pins synchronous to mclk, one strobe at a time
// Notes:   decode is live; writes are handed on when the strobe ends
//
// Summary of operation
// - map A fixed registers ignore page-in
// - map A paged registers only after page-in
// - map B added registers use spare codes
// - map B swapped register appears at code two
// - swapped register stays until reswap or reset
// - map B base registers never move
// - map B status four/five only once present
// - map A page-out after next CPU access
// - DMA grant routes to data registers
`timescale 1ns/1ps

module dual_map_host_register_decoder
  import dual_map_pkg::*;
#(
  parameter logic [7:0] REVISION_ID = 8'h5A  // arbitrary value
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [2:0] register_pick_lines,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       dma_grant_n,
  input  wire logic       map_b_sel,
  input  wire logic [7:0] host_bus_rx,
  output logic      [7:0] host_bus_tx,
  output logic            host_bus_tx_en_n,
  output reg_id_t         access_target,
  input  wire logic [7:0] block_rd_value,
  output logic            write_pulse,
  output reg_id_t         write_target,
  output logic      [7:0] write_byte,
  output logic            read_done_pulse,
  output reg_id_t         read_done_target,
  output logic            page_a_active,
  output logic      [1:0] swap_choice,
  output logic            extra_present
);

  typedef struct packed {
    logic       act;
    logic       is_wr;
    logic       is_dma;
    reg_id_t    tgt;
    logic [7:0] wbyte;
    logic       wpulse;
    logic       rpulse;
    logic [7:0] dout;
    logic       paged_a;
    logic [1:0] swap;
    logic       present;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   rd_act;
  logic   wr_act;
  logic   cur_act;
  logic   ended;
  logic   a_cmd;
  logic   b_cmd;
  reg_id_t live;

  // map B select two: whichever register was last swapped in
  function automatic reg_id_t swap_reg(input logic [1:0] sw);
    case (sw)
      SWAP_MASK_TWO: swap_reg = B_EVENT_ENABLE_TWO;
      SWAP_TERM:     swap_reg = B_TERMINATOR_CHAR;
      SWAP_LINE:     swap_reg = B_LINE_CONTROL;
      default:       swap_reg = B_EXTRA_SETTINGS;
    endcase
  endfunction : swap_reg

  // full decode of one access from the select lines and banking state
  function automatic reg_id_t decode(
    input logic       mb,
    input logic       pg,
    input logic [1:0] sw,
    input logic       pr,
    input logic [2:0] sel,
    input logic       wr,
    input logic       dma
  );
    decode = REG_NONE;
    if (dma) begin
      // grant overrides select and chip select
      if (mb) decode = wr ? B_TX_BYTE_OR_CMD : B_RX_BYTE;
      else    decode = wr ? A_TX_BYTE_OR_CMD : A_RX_BYTE;
    end else if (!mb) begin
      case (sel)
        SEL_0: decode = wr ? A_TX_BYTE_OR_CMD : A_RX_BYTE;
        SEL_1: decode = wr ? A_EVENT_ENABLE_ONE : A_EVENT_FLAGS_ONE;
        SEL_2: decode = wr ? A_EVENT_ENABLE_TWO : A_EVENT_FLAGS_TWO;
        SEL_3: begin
          if (pg) decode = wr ? A_CLOCK_DIVIDER_SETTING : A_CHIP_REVISION;
          else    decode = wr ? A_POLL_RESPONSE_SETUP : A_POLL_RESPONSE_STATE;
        end
        SEL_4: decode = wr ? A_ADDRESSING_SETUP : A_ADDRESSING_STATE;
        SEL_5: begin
          // aux mode write is fixed; only the read side is paged
          if (wr)      decode = A_AUX_COMMAND_PORT;
          else if (pg) decode = A_HANDSHAKE_STATE;
          else         decode = A_PASSED_COMMAND;
        end
        SEL_6: begin
          if (pg) decode = wr ? A_EVENT_ENABLE_ZERO : A_EVENT_FLAGS_ZERO;
          else    decode = wr ? A_OWN_BUS_ADDRESS : A_PRIMARY_ADDR_READBACK;
        end
        default: begin
          if (pg) decode = wr ? A_LINE_CONTROL : A_LINE_STATE;
          else    decode = wr ? A_TERMINATOR_CHAR : A_SECONDARY_ADDR_READBACK;
        end
      endcase
    end else begin
      case (sel)
        SEL_0: decode = wr ? B_EVENT_ENABLE_ZERO : B_EVENT_FLAGS_ZERO;
        SEL_1: decode = wr ? B_EVENT_ENABLE_ONE : B_EVENT_FLAGS_ONE;
        SEL_2: begin
          // nothing writable here until the first swap
          if (!wr)     decode = B_ADDRESSING_STATE;
          else if (pr) decode = swap_reg(sw);
          else         decode = REG_NONE;
        end
        SEL_3: decode = wr ? B_AUX_COMMAND_PORT : B_LINE_STATE;
        SEL_4: begin
          if (wr)      decode = B_OWN_BUS_ADDRESS;
          else if (pr) decode = B_EVENT_FLAGS_TWO;
          else         decode = REG_NONE;
        end
        SEL_5: begin
          if (wr)      decode = B_POLL_RESPONSE_SETUP;
          else if (pr) decode = B_POLL_RESPONSE_STATE;
          else         decode = REG_NONE;
        end
        SEL_6: decode = wr ? B_GROUP_POLL_SETUP : B_PASSED_COMMAND;
        default: decode = wr ? B_TX_BYTE_OR_CMD : B_RX_BYTE;
      endcase
    end
  endfunction : decode

  // strobe qualification; a strobe pair counts as no access
  always_comb begin
    rd_act  = !rd_n && wr_n && (!cs_n || !dma_grant_n);
    wr_act  = !wr_n && rd_n && (!cs_n || !dma_grant_n);
    cur_act = rd_act || wr_act;
    ended   = s_q.act && !cur_act;
    live    = decode(map_b_sel, s_q.paged_a, s_q.swap, s_q.present,
                     register_pick_lines, wr_act, !dma_grant_n);
    a_cmd   = s_q.is_wr && (s_q.tgt == A_AUX_COMMAND_PORT) && (s_q.wbyte == A_PAGE_CMD);
    b_cmd   = s_q.is_wr && (s_q.tgt == B_AUX_COMMAND_PORT)
              && ((s_q.wbyte & B_PAGE_MASK) == B_PAGE_CODE);
  end

  // next state: sample during the strobe, act on its trailing edge
  always_comb begin
    s_d        = s_q;
    s_d.wpulse = 1'b0;
    s_d.rpulse = 1'b0;
    s_d.act    = cur_act;
    if (cur_act) begin
      s_d.is_wr  = wr_act;
      s_d.is_dma = !dma_grant_n;
      s_d.tgt    = live;
    end
    // last sampled byte before the rising strobe is the one written
    if (wr_act) begin
      s_d.wbyte = host_bus_rx;
    end
    // read data held in flops so the bus sees a clean value
    if (rd_act) begin
      if (live == A_CHIP_REVISION) s_d.dout = REVISION_ID;
      else if (live == REG_NONE)   s_d.dout = BYTE_ZERO;
      else                         s_d.dout = block_rd_value;
    end
    if (ended) begin
      s_d.wpulse = s_q.is_wr;
      s_d.rpulse = !s_q.is_wr;
      // DMA cycles are not CPU accesses and leave banking alone
      if (!s_q.is_dma) begin
        s_d.paged_a = a_cmd;
        if (b_cmd) begin
          s_d.swap    = s_q.wbyte[SWAP_LSB +: SWAP_W];
          s_d.present = 1'b1;
        end
      end
    end
  end

  // single state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign access_target    = live;
  assign host_bus_tx      = s_q.dout;
  assign host_bus_tx_en_n = !rd_act;
  assign write_pulse      = s_q.wpulse;
  assign write_target     = s_q.tgt;
  assign write_byte       = s_q.wbyte;
  assign read_done_pulse  = s_q.rpulse;
  assign read_done_target = s_q.tgt;
  assign page_a_active    = s_q.paged_a;
  assign swap_choice      = s_q.swap;
  assign extra_present    = s_q.present;

  // checks kept beside the decode they guard
  chk_a_fixed_one: assert property (
    @(posedge mclk) disable iff (rst)
    (!map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_1)
      |-> access_target == A_EVENT_FLAGS_ONE)
    else $error("map A select one moved");

  chk_a_paged_rev: assert property (
    @(posedge mclk) disable iff (rst)
    (!map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_3)
      |-> (access_target == (page_a_active ? A_CHIP_REVISION : A_POLL_RESPONSE_STATE)))
    else $error("map A select three wrong bank");

  chk_b_added_two: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_4
      && extra_present) |=> host_bus_tx == $past(block_rd_value))
    else $error("map B status two not returned");

  chk_b_swap_load: assert property (
    @(posedge mclk) disable iff (rst)
    (ended && !s_q.is_dma && b_cmd)
      |=> (swap_choice == $past(s_q.wbyte[SWAP_LSB +: SWAP_W])) && extra_present)
    else $error("swap choice not loaded");

  chk_b_swap_hold: assert property (
    @(posedge mclk) disable iff (rst)
    !$stable(swap_choice) |-> $past(ended && !s_q.is_dma && b_cmd))
    else $error("swap changed without command");

  chk_b_base_fixed: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && wr_act && register_pick_lines == SEL_3)
      |-> access_target == B_AUX_COMMAND_PORT)
    else $error("map B aux command moved");

  chk_b_absent_zero: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_5
      && !extra_present) |=> host_bus_tx == BYTE_ZERO)
    else $error("poll state read before present");

  chk_a_page_out: assert property (
    @(posedge mclk) disable iff (rst)
    (page_a_active && ended && !s_q.is_dma && !a_cmd) |=> !page_a_active [*2])
    else $error("page-in survived next access");

  chk_dma_route: assert property (
    @(posedge mclk) disable iff (rst)
    (!dma_grant_n && wr_act) |->
      access_target == (map_b_sel ? B_TX_BYTE_OR_CMD : A_TX_BYTE_OR_CMD))
    else $error("dma write misrouted");

  // map A decode and banking: the rest of the fixed and paged codes
  chk_a_fixed_zero: assert property (
    @(posedge mclk) disable iff (rst)
    (!map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_0)
      |-> access_target == A_RX_BYTE)
    else $error("map A select zero moved");

  chk_a_fixed_two: assert property (
    @(posedge mclk) disable iff (rst)
    (!map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_2)
      |-> access_target == A_EVENT_FLAGS_TWO)
    else $error("map A select two moved");

  chk_a_fixed_four: assert property (
    @(posedge mclk) disable iff (rst)
    (!map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_4)
      |-> access_target == A_ADDRESSING_STATE)
    else $error("map A select four moved");

  chk_a_aux_fixed: assert property (
    @(posedge mclk) disable iff (rst)
    (!map_b_sel && dma_grant_n && !cs_n && wr_act && register_pick_lines == SEL_5)
      |-> access_target == A_AUX_COMMAND_PORT)
    else $error("map A aux mode write moved");

  chk_a_paged_six: assert property (
    @(posedge mclk) disable iff (rst)
    (!map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_6)
      |-> (access_target == (page_a_active ? A_EVENT_FLAGS_ZERO : A_PRIMARY_ADDR_READBACK)))
    else $error("map A select six wrong bank");

  chk_a_paged_seven: assert property (
    @(posedge mclk) disable iff (rst)
    (!map_b_sel && dma_grant_n && !cs_n && wr_act && register_pick_lines == SEL_7)
      |-> (access_target == (page_a_active ? A_LINE_CONTROL : A_TERMINATOR_CHAR)))
    else $error("map A select seven wrong bank");

  chk_a_rev_data: assert property (
    @(posedge mclk) disable iff (rst)
    (rd_act && access_target == A_CHIP_REVISION) |=> host_bus_tx == REVISION_ID)
    else $error("revision read wrong byte");

  chk_a_page_in: assert property (
    @(posedge mclk) disable iff (rst)
    (ended && !s_q.is_dma && a_cmd) |=> page_a_active)
    else $error("page-in command not taken");

  chk_dma_keeps_bank: assert property (
    @(posedge mclk) disable iff (rst)
    (ended && s_q.is_dma) |=> page_a_active == $past(page_a_active))
    else $error("dma cycle changed page-in");

  // map B decode and DMA reads
  chk_b_base_zero: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_0)
      |-> access_target == B_EVENT_FLAGS_ZERO)
    else $error("map B select zero moved");

  chk_b_base_seven: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_7)
      |-> access_target == B_RX_BYTE)
    else $error("map B select seven moved");

  chk_b_refuse_two: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && wr_act && register_pick_lines == SEL_2
      && !extra_present) |-> access_target == REG_NONE)
    else $error("map B select two writable before swap");

  chk_b_swap_term: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && wr_act && register_pick_lines == SEL_2
      && extra_present && swap_choice == SWAP_TERM) |-> access_target == B_TERMINATOR_CHAR)
    else $error("terminator not at select two");

  chk_b_swap_extra: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && wr_act && register_pick_lines == SEL_2
      && extra_present && swap_choice == SWAP_EXTRA) |-> access_target == B_EXTRA_SETTINGS)
    else $error("extra settings not at select two");

  chk_b_present_hold: assert property (
    @(posedge mclk) disable iff (rst)
    extra_present |=> extra_present)
    else $error("swap presence lost without reset");

  chk_b_flags_two: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_4)
      |-> (access_target == (extra_present ? B_EVENT_FLAGS_TWO : REG_NONE)))
    else $error("map B select four wrong target");

  chk_b_added_five: assert property (
    @(posedge mclk) disable iff (rst)
    (map_b_sel && dma_grant_n && !cs_n && rd_act && register_pick_lines == SEL_5
      && extra_present) |-> access_target == B_POLL_RESPONSE_STATE)
    else $error("map B poll state not at select five");

  chk_dma_read: assert property (
    @(posedge mclk) disable iff (rst)
    (!dma_grant_n && rd_act) |->
      access_target == (map_b_sel ? B_RX_BYTE : A_RX_BYTE))
    else $error("dma read misrouted");

endmodule : dual_map_host_register_decoder

// ### verification/host_cpu_model.sv
// Purpose: host CPU and DMA controller model for the register decoder
// Assumes: one access at a time, strobe held three edges, idle gap after
// Notes:   captures live decode and read data while the strobe still stands
`timescale 1ns/1ps

module host_cpu_model
  import dual_map_pkg::*;
(
  input  wire logic       mclk,
  input  wire reg_id_t    access_target,
  input  wire logic [7:0] host_bus_tx,
  output logic      [2:0] register_pick_lines,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            dma_grant_n,
  output logic      [7:0] host_bus_rx,
  output reg_id_t         seen_target,
  output logic      [7:0] seen_data
);
  // bus idle at time zero
  initial begin
    {cs_n, rd_n, wr_n, dma_grant_n} = 4'hF;
    register_pick_lines = 3'h0;
    host_bus_rx = 8'h00;
    seen_target = REG_NONE;
    seen_data = 8'h00;
  end

  // one access; the idle tail lets the decoder see the strobe end
  task automatic access(input logic [2:0] sel, input logic wr, input logic dma, input logic [7:0] data);
    @(posedge mclk);
    register_pick_lines <= sel;
    cs_n <= dma;
    dma_grant_n <= ~dma;
    rd_n <= wr;
    wr_n <= ~wr;
    host_bus_rx <= data;
    repeat (3) @(posedge mclk);
    seen_target <= access_target;
    seen_data <= host_bus_tx;
    {cs_n, rd_n, wr_n, dma_grant_n} <= 4'hF;
    host_bus_rx <= ~data;  // released bus must not show a stale byte
    register_pick_lines <= ~sel;
    repeat (3) @(posedge mclk);
  endtask : access
endmodule : host_cpu_model

// ### verification/dual_map_host_register_decoder_tb.sv
// Purpose: self-checking bench for the dual map register decoder
// Assumes: map select changes only between accesses
// Notes:   read data from the interface side is a byte that names the register
`timescale 1ns/1ps

module dual_map_host_register_decoder_tb
  import dual_map_pkg::*;
();
  logic mclk, rst, map_b_sel, tx_en_n, wp, rdp, pa, xp;
  logic [2:0] sel;
  logic cs_n, rd_n, wr_n, dg_n;
  logic [7:0] rx, tx, wb, sd;
  logic [1:0] sw;
  reg_id_t at, wt, rt, st;
  int failures = 0;
  int comparisons = 0;
  int wp_seen = 0;
  int rdp_seen = 0;
  int en_seen = 0;
  logic [7:0] bv;
  reg_id_t exp_b[4] = '{B_EVENT_ENABLE_TWO, B_TERMINATOR_CHAR, B_LINE_CONTROL, B_EXTRA_SETTINGS};

  dual_map_host_register_decoder #(.REVISION_ID(8'h3C)) DUT (.mclk(mclk), .rst(rst),
    .register_pick_lines(sel), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .dma_grant_n(dg_n),
    .map_b_sel(map_b_sel), .host_bus_rx(rx), .host_bus_tx(tx), .host_bus_tx_en_n(tx_en_n),
    .access_target(at), .block_rd_value(bv), .write_pulse(wp), .write_target(wt),
    .write_byte(wb), .read_done_pulse(rdp), .read_done_target(rt), .page_a_active(pa),
    .swap_choice(sw), .extra_present(xp));

  host_cpu_model hm (.mclk(mclk), .access_target(at), .host_bus_tx(tx), .register_pick_lines(sel),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .dma_grant_n(dg_n), .host_bus_rx(rx),
    .seen_target(st), .seen_data(sd));

  // interface side answers with a byte naming the register asked for, so a misroute shows in the data
  function automatic logic [7:0] rdv(input reg_id_t r);
    rdv = {2'b10, 6'(r)};
  endfunction : rdv

  assign bv = rdv(at);

  // pulses and the read enable stand briefly; judge them mid-cycle where they have settled
  always @(negedge mclk) begin
    if (wp === 1'b1) wp_seen++;
    if (rdp === 1'b1) rdp_seen++;
    if (tx_en_n === 1'b0) en_seen++;
  end

  // clock at 40 MHz
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one access, then compare the decode seen while the strobe stood
  task automatic hit(input logic [2:0] s, input logic w, input logic d, input logic [7:0] v, input reg_id_t e);
    int wp0;
    int rp0;
    int en0;
    wp0 = wp_seen;
    rp0 = rdp_seen;
    en0 = en_seen;
    hm.access(s, w, d, v);
    check("access_target", 8'(e), 8'(st));
    check("write_pulse", 8'(w), 8'(wp_seen - wp0));
    check("read_done_pulse", 8'(!w), 8'(rdp_seen - rp0));
    check("host_bus_tx_en_n", w ? 8'h00 : 8'h03, 8'(en_seen - en0));
    if (w) begin
      check("write_target", 8'(e), 8'(wt));
    end else begin
      check("read_done_target", 8'(e), 8'(rt));
    end
  endtask : hit

  task automatic test_map_a_fixed();
    hit(3'h0, 1'b0, 1'b0, 8'h00, A_RX_BYTE);
    check("host_bus_tx", rdv(A_RX_BYTE), sd);
    hit(3'h2, 1'b0, 1'b0, 8'h00, A_EVENT_FLAGS_TWO);
    hit(3'h1, 1'b1, 1'b0, 8'h11, A_EVENT_ENABLE_ONE);
    check("write_byte", 8'h11, wb);
    hit(3'h4, 1'b0, 1'b0, 8'h00, A_ADDRESSING_STATE);
  endtask : test_map_a_fixed

  task automatic test_map_a_page();
    hit(3'h3, 1'b0, 1'b0, 8'h00, A_POLL_RESPONSE_STATE);
    hit(3'h5, 1'b1, 1'b0, 8'h50, A_AUX_COMMAND_PORT);
    check("page_a_active", 8'h01, 8'(pa));
    hit(3'h1, 1'b0, 1'b0, 8'h00, A_EVENT_FLAGS_ONE);
    check("page_a_active", 8'h00, 8'(pa));
    hit(3'h5, 1'b1, 1'b0, 8'h50, A_AUX_COMMAND_PORT);
    hit(3'h3, 1'b0, 1'b0, 8'h00, A_CHIP_REVISION);
    check("revision", 8'h3C, sd);
    hit(3'h3, 1'b0, 1'b0, 8'h00, A_POLL_RESPONSE_STATE);
    hit(3'h5, 1'b1, 1'b0, 8'h50, A_AUX_COMMAND_PORT);
    hit(3'h7, 1'b1, 1'b0, 8'hAA, A_LINE_CONTROL);
    check("write_target", 8'(A_LINE_CONTROL), 8'(wt));
    hit(3'h5, 1'b1, 1'b0, 8'h50, A_AUX_COMMAND_PORT);
    hit(3'h6, 1'b0, 1'b0, 8'h00, A_EVENT_FLAGS_ZERO);
  endtask : test_map_a_page

  // DMA cycles ignore select and chip select in both maps
  task automatic test_dma(input logic b);
    hit(3'h5, 1'b1, 1'b0, 8'h50, b ? B_POLL_RESPONSE_SETUP : A_AUX_COMMAND_PORT);
    hit(3'h5, 1'b0, 1'b1, 8'h00, b ? B_RX_BYTE : A_RX_BYTE);
    hit(3'h2, 1'b1, 1'b1, 8'h77, b ? B_TX_BYTE_OR_CMD : A_TX_BYTE_OR_CMD);
    check("write_target", 8'(b ? B_TX_BYTE_OR_CMD : A_TX_BYTE_OR_CMD), 8'(wt));
    check("page_a_active", 8'(!b), 8'(pa));
    hit(3'h3, 1'b0, 1'b0, 8'h00, b ? B_LINE_STATE : A_CHIP_REVISION);
    check("page_a_active", 8'h00, 8'(pa));
  endtask : test_dma

  task automatic test_map_b();
    hit(3'h4, 1'b0, 1'b0, 8'h00, REG_NONE);
    check("host_bus_tx", 8'h00, sd);
    hit(3'h5, 1'b0, 1'b0, 8'h00, REG_NONE);
    check("host_bus_tx", 8'h00, sd);
    hit(3'h2, 1'b1, 1'b0, 8'h0F, REG_NONE);
    check("write_target", 8'(REG_NONE), 8'(wt));
    for (int i = 0; i < 4; i++) begin
      hit(3'h3, 1'b1, 1'b0, {6'h14, 2'(i)}, B_AUX_COMMAND_PORT);
      hit(3'h2, 1'b1, 1'b0, 8'h0F, exp_b[i]);
      check("write_byte", 8'h0F, wb);
      hit(3'h0, 1'b0, 1'b0, 8'h00, B_EVENT_FLAGS_ZERO);
      hit(3'h2, 1'b1, 1'b0, 8'h0F, exp_b[i]);
    end
    hit(3'h4, 1'b0, 1'b0, 8'h00, B_EVENT_FLAGS_TWO);
    check("host_bus_tx", rdv(B_EVENT_FLAGS_TWO), sd);
    hit(3'h5, 1'b0, 1'b0, 8'h00, B_POLL_RESPONSE_STATE);
    hit(3'h3, 1'b0, 1'b0, 8'h00, B_LINE_STATE);
    hit(3'h7, 1'b0, 1'b0, 8'h00, B_RX_BYTE);
  endtask : test_map_b

  // a reset in mid-run drops the swapped-in register
  task automatic test_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    check("swap_choice", 8'h00, 8'(sw));
    check("extra_present", 8'h00, 8'(xp));
    hit(3'h2, 1'b1, 1'b0, 8'h01, REG_NONE);
    check("write_target", 8'(REG_NONE), 8'(wt));
  endtask : test_reset

  task automatic report_and_stop();
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst = 1'b1;
    map_b_sel = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    test_map_a_fixed();
    test_map_a_page();
    test_dma(1'b0);
    map_b_sel <= 1'b1;
    test_map_b();
    test_dma(1'b1);
    test_reset();
    report_and_stop();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    report_and_stop();
  end
endmodule : dual_map_host_register_decoder_tb
